/* sim/pwm_port_checker_assertions.sv */
// Port-level checker of the sawtooth PWM channel
`timescale 1ns/1ps
`include "pwm_consts.svh"

module pwm_port_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pwm_out_a,
    input wire logic        irq
);
    // --------
    // Shadow of the software view
    // --------
    logic       wr;
    logic       start;
    logic       calm;
    logic [1:0] sel_r;
    logic       at_r;
    logic       run_r;
    logic       live_r;
    logic [7:0] per_r;
    logic       per_ok_r;
    logic [9:0] age_r;

    assign wr    = psel & penable & pready & pwrite;
    assign start = wr & (paddr == `OFS_CTRL) & pwdata[0] & ~run_r;
    // Two full periods after a forcing write while running; short periods only
    assign calm  = run_r & live_r & per_ok_r & (age_r > ({1'b0, per_r, 1'b0} + 10'h004));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_r  <= 2'h0;
            at_r   <= 1'b0;
            run_r  <= 1'b0;
            live_r <= 1'b0;
            per_r  <= 8'hFF;
            per_ok_r <= 1'b0;
        end else begin
            if (wr && paddr == `OFS_DUTY_FORCE) begin
                sel_r  <= pwdata[1:0];
                at_r   <= pwdata[2];
                live_r <= run_r;
            end
            if (wr && paddr == `OFS_CTRL) begin
                run_r  <= pwdata[0];
                live_r <= 1'b0;
            end
            if (wr && paddr == `OFS_PERIOD) begin
                per_r <= pwdata[7:0];
                per_ok_r <= (pwdata[31:8] == 24'h000000);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 10'h000;
        end else if (wr) begin
            age_r <= 10'h000;
        end else if (age_r != 10'h3FF) begin
            age_r <= age_r + 10'h001;
        end
    end

    // --------
    // Assertions
    // --------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wait_state: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not one cycle into access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (psel && penable && pready && paddr > `OFS_IRQ_EN |-> pslverr)
        else $error("unmapped access without error");
    a_start_forced: assert property (start && at_r && sel_r[1] |=> pwm_out_a == sel_r[0])
        else $error("forced level missing at start");
    a_start_low: assert property (start && !(at_r && sel_r[1]) |=> !pwm_out_a)
        else $error("pin not low at start");
    a_force_high: assert property (calm && sel_r == `DUTY_FORCE_HIGH |-> pwm_out_a)
        else $error("forced high not held");
    a_force_low: assert property (calm && sel_r == `DUTY_FORCE_LOW |-> !pwm_out_a)
        else $error("forced low not held");
    a_stop_holds: assert property (!run_r && age_r > 10'h001 |-> $stable(pwm_out_a))
        else $error("pin moved while stopped");

    c_start_forced: cover property (start && at_r && sel_r[1]);
    c_force_calm: cover property (calm);
    c_error: cover property (pslverr);
    c_irq: cover property (irq);
endmodule

bind sawtooth_pwm_forced_duty pwm_port_checker pwm_port_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out_a(pwm_out_a), .irq(irq)
);

/* sim/tb.sv */
// Self-checking bench for the sawtooth PWM channel
`timescale 1ns/1ps
`include "pwm_consts.svh"

module tb;
    localparam int P = 5;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pwm_out_a;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          hi;
    int          err_count;
    int          compares;
    // Rows: compare value, duty force word, high clocks over three periods from start
    int          row_c [7] = '{2, 0, 5, 9, 1, 1, 1};
    logic [2:0]  row_d [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h6, 3'h3};
    int          row_e [7] = '{9, 15, 12, 0, 18, 0, 16};

    sawtooth_pwm_forced_duty #(.CNT_W(32)) sawtooth_pwm_forced_duty_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pwm_out_a(pwm_out_a), .irq(irq)
    );

    // --------
    // Tasks
    // --------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, name);
    endtask

    task automatic meas(input int skip, input int n);
        hi = 0;
        repeat (skip) @(negedge pclk);
        repeat (n) begin
            @(negedge pclk);
            if (pwm_out_a === 1'b1) hi++;
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // --------
    // Main sequence
    // --------
    initial begin
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_count = 0;
        compares = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFS_PERIOD, `PERIOD_RST, "period_value");
        rdchk(`OFS_COMPARE_A, `COMPARE_RST, "compare_a");
        rdchk(`OFS_COUNT, `COUNT_INIT, "timer_count");
        rdchk(`OFS_DUTY_FORCE, 32'h0, "duty_force_ctrl");
        rdchk(12'h030, 32'h0, "unmapped read");
        chk({31'h0, er}, 32'h1, "pslverr");
        wr(`OFS_PERIOD, P);
        for (int i = 0; i < 7; i++) begin
            wr(`OFS_COUNT, 32'h0);
            wr(`OFS_COMPARE_A, row_c[i]);
            wr(`OFS_DUTY_FORCE, {29'h0, row_d[i]});
            wr(`OFS_CTRL, 32'h1);
            meas(0, 3 * (P + 1));
            chk(hi, row_e[i], "high clocks");
            wr(`OFS_CTRL, 32'h0);
        end
        // Forcing changed while counting
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_COMPARE_A, 32'h2);
        wr(`OFS_DUTY_FORCE, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_DUTY_FORCE, {30'h0, `DUTY_FORCE_HIGH});
        meas(12, 12);
        chk(hi, 12, "forced high");
        rdchk(`OFS_CTRL, 32'h101, "ctrl running");
        wr(`OFS_DUTY_FORCE, {30'h0, `DUTY_FORCE_LOW});
        meas(12, 12);
        chk(hi, 0, "forced low");
        wr(`OFS_DUTY_FORCE, 32'h0);
        meas(12, 12);
        chk(hi, 6, "released");
        wr(`OFS_CTRL, 32'h0);
        // Events, buffer transfer and interrupt while forced
        wr(`OFS_STATUS_CLR, 32'h7);
        wr(`OFS_COUNT, 32'h0);
        wr(`OFS_COMPARE_A, 32'h1);
        wr(`OFS_COMPARE_A_BUF, 32'h2);
        wr(`OFS_COMPARE_B, 32'h3);
        wr(`OFS_DUTY_FORCE, 32'h7);
        wr(`OFS_IRQ_EN, 32'h1);
        wr(`OFS_CTRL, 32'h3);
        n = 0;
        while (irq !== 1'b1 && n < 50) begin
            @(negedge pclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1, "irq overflow");
        wr(`OFS_CTRL, 32'h0);
        rdchk(`OFS_STATUS, 32'h7, "status");
        rdchk(`OFS_COMPARE_A, 32'h2, "buffer transfer");
        wr(`OFS_IRQ_EN, 32'h0);
        repeat (3) @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`OFS_IRQ_EN, 32'h1);
        wr(`OFS_STATUS_CLR, 32'h7);
        rdchk(`OFS_STATUS, 32'h0, "status cleared");
        repeat (3) @(negedge pclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        // Reset in mid-run
        wr(`OFS_CTRL, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk({31'h0, pwm_out_a}, 32'h0, "pin in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFS_CTRL, 32'h0, "ctrl after reset");
        rdchk(`OFS_DUTY_FORCE, 32'h0, "duty after reset");
        finish_test();
    end
endmodule

/* src/pwm_consts.svh */
// Register offsets, field positions, encodings and reset values of the PWM channel
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

`define ADDR_W              12
`define OFS_CTRL            12'h000
`define OFS_DUTY_FORCE      12'h004
`define OFS_PERIOD          12'h008
`define OFS_COMPARE_A       12'h00C
`define OFS_COMPARE_B       12'h010
`define OFS_COMPARE_A_BUF   12'h014
`define OFS_COUNT           12'h018
`define OFS_STATUS          12'h01C
`define OFS_STATUS_CLR      12'h020
`define OFS_IRQ_EN          12'h024

`define CTRL_RUN_BIT        0
`define CTRL_BUF_EN_BIT     1
`define CTRL_OUT_BIT        8

`define DUTY_SEL_LSB        0
`define DUTY_SEL_MSB        1
`define DUTY_AT_START_BIT   2

`define DUTY_NONE           2'h0
`define DUTY_FORCE_LOW      2'h2
`define DUTY_FORCE_HIGH     2'h3

`define EVT_W               3
`define EVT_OVERFLOW_BIT    0
`define EVT_MATCH_A_BIT     1
`define EVT_MATCH_B_BIT     2

`define PERIOD_RST          32'hFFFF_FFFF
`define COMPARE_RST         32'hFFFF_FFFF
`define COUNT_INIT          32'h0000_0000

`endif

/* src/pwm_pkg.sv */
// Types shared by the PWM channel files
package pwm_pkg;

    typedef enum logic {
        ST_STOPPED,
        ST_COUNTING
    } run_state_t;

endpackage

/* src/sawtooth_counter.sv */
// Up-counting sawtooth counter with period wrap and compare detection
`timescale 1ns/1ps
`include "pwm_consts.svh"

module sawtooth_counter #(
    parameter int CNT_W = 32
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             run,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] load_val,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic [CNT_W-1:0] cmp_a,
    input  wire logic [CNT_W-1:0] cmp_b,
    output logic      [CNT_W-1:0] count,
    output logic                  overflow,
    output logic                  match_a,
    output logic                  match_b
);

    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    // ------------------------------------------------------------
    // Count
    // ------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (run) begin
            if (count_r == period) begin
                count_nxt = '0;
            end else begin
                count_nxt = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end else if (load) begin
            count_nxt = load_val;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------
    // Events of the current count
    // ------------------------------------------------------------
    // A compare above the period never equals the count
    assign overflow = run && (count_r == period);
    assign match_a  = run && (count_r == cmp_a);
    assign match_b  = run && (count_r == cmp_b);
    assign count    = count_r;

endmodule

/* src/sawtooth_pwm_forced_duty.sv */
// Sawtooth PWM channel with forced 0%/100% duty and APB registers
// Summary of operation
// - Forced selection 10b drives the output low, 11b drives it high.
// - With at-start flag set while stopped, forced level appears as counting begins.
// - With at-start flag clear, a selection made while stopped is not applied at start.
// - Writing 11b while counting gives constant high from the next PWM cycle.
// - Writing 10b while counting gives constant low from the next PWM cycle.
// - A compare value above the period never matches; the output stays low.
// - Compare value 0 gives one count clock low after overflow, then high.
// - Coincident overflow and compare match: the compare-match change wins.
// - While forced, matches, match interrupts and buffer transfers continue.
// - While forced, compare matches on channel A do not change the output.
// - Normally low at start, high at compare A match, low at cycle end.
// - Counter counts up from 0 and wraps at the period value.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "pwm_consts.svh"

module sawtooth_pwm_forced_duty #(
    parameter int CNT_W = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pwm_out_a,
    output logic             irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pwm_pkg::run_state_t state_r;

    logic [CNT_W-1:0]       period_value_r;
    logic [CNT_W-1:0]       compare_a_r;
    logic [CNT_W-1:0]       compare_b_r;
    logic [CNT_W-1:0]       compare_a_buffer_r;
    logic [1:0]             forced_duty_sel_a_r;
    logic                   forced_duty_at_start_a_r;
    logic                   buf_en_r;
    logic [1:0]             force_act_r;
    logic [1:0]             force_nxt;
    logic                   level_r;
    logic                   level_nxt;
    logic                   out_nxt;
    logic [`EVT_W-1:0]      status_r;
    logic [`EVT_W-1:0]      irq_en_r;
    logic [`EVT_W-1:0]      events;
    logic [31:0]            rdata_nxt;
    logic                   addr_ok;

    logic [CNT_W-1:0]       timer_count;
    logic                   overflow;
    logic                   match_a;
    logic                   match_b;
    logic                   running;
    logic                   start_req;
    logic                   stop_req;
    logic                   cnt_load;

    logic                   acc_done;
    logic                   wr_done;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // True when a selection code forces the pin
    function automatic logic is_forced(input logic [1:0] sel);
        is_forced = (sel == `DUTY_FORCE_LOW) || (sel == `DUTY_FORCE_HIGH);
    endfunction

    // Pin level from the active forcing and the compare-driven level
    function automatic logic pin_level(input logic [1:0] act, input logic lvl);
        if (act == `DUTY_FORCE_LOW) begin
            pin_level = 1'b0;
        end else if (act == `DUTY_FORCE_HIGH) begin
            pin_level = 1'b1;
        end else begin
            pin_level = lvl;
        end
    endfunction

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // One wait state: pready rises one cycle into the access phase
    assign acc_done = psel && penable && pready;
    assign wr_done  = acc_done && pwrite;

    always_comb begin
        addr_ok = 1'b1;
        case (paddr)
            `OFS_CTRL,
            `OFS_DUTY_FORCE,
            `OFS_PERIOD,
            `OFS_COMPARE_A,
            `OFS_COMPARE_B,
            `OFS_COMPARE_A_BUF,
            `OFS_COUNT,
            `OFS_STATUS,
            `OFS_STATUS_CLR,
            `OFS_IRQ_EN: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL: begin
                rdata_nxt[`CTRL_RUN_BIT]    = running;
                rdata_nxt[`CTRL_BUF_EN_BIT] = buf_en_r;
                rdata_nxt[`CTRL_OUT_BIT]    = pwm_out_a;
            end
            `OFS_DUTY_FORCE: begin
                rdata_nxt[`DUTY_SEL_MSB:`DUTY_SEL_LSB] = forced_duty_sel_a_r;
                rdata_nxt[`DUTY_AT_START_BIT]         = forced_duty_at_start_a_r;
            end
            `OFS_PERIOD:        rdata_nxt[CNT_W-1:0] = period_value_r;
            `OFS_COMPARE_A:     rdata_nxt[CNT_W-1:0] = compare_a_r;
            `OFS_COMPARE_B:     rdata_nxt[CNT_W-1:0] = compare_b_r;
            `OFS_COMPARE_A_BUF: rdata_nxt[CNT_W-1:0] = compare_a_buffer_r;
            `OFS_COUNT:         rdata_nxt[CNT_W-1:0] = timer_count;
            `OFS_STATUS:        rdata_nxt[`EVT_W-1:0] = status_r;
            `OFS_IRQ_EN:        rdata_nxt[`EVT_W-1:0] = irq_en_r;
            default:            rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            forced_duty_sel_a_r      <= `DUTY_NONE;
            forced_duty_at_start_a_r <= 1'b0;
            buf_en_r                 <= 1'b0;
            period_value_r           <= CNT_W'(`PERIOD_RST);
            compare_b_r              <= CNT_W'(`COMPARE_RST);
            compare_a_buffer_r       <= CNT_W'(`COMPARE_RST);
            irq_en_r                 <= '0;
        end else if (wr_done) begin
            case (paddr)
                `OFS_CTRL: buf_en_r <= pwdata[`CTRL_BUF_EN_BIT];
                `OFS_DUTY_FORCE: begin
                    forced_duty_sel_a_r      <= pwdata[`DUTY_SEL_MSB:`DUTY_SEL_LSB];
                    forced_duty_at_start_a_r <= pwdata[`DUTY_AT_START_BIT];
                end
                `OFS_PERIOD:        period_value_r     <= pwdata[CNT_W-1:0];
                `OFS_COMPARE_B:     compare_b_r        <= pwdata[CNT_W-1:0];
                `OFS_COMPARE_A_BUF: compare_a_buffer_r <= pwdata[CNT_W-1:0];
                `OFS_IRQ_EN:        irq_en_r           <= pwdata[`EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // Compare A: software write, or buffer transfer at overflow while buf_en_r is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_r <= CNT_W'(`COMPARE_RST);
        end else if (overflow && buf_en_r) begin
            compare_a_r <= compare_a_buffer_r;
        end else if (wr_done && paddr == `OFS_COMPARE_A) begin
            compare_a_r <= pwdata[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    assign running   = (state_r == pwm_pkg::ST_COUNTING);
    assign start_req = wr_done && paddr == `OFS_CTRL && pwdata[`CTRL_RUN_BIT] && !running;
    assign stop_req  = wr_done && paddr == `OFS_CTRL && !pwdata[`CTRL_RUN_BIT] && running;
    assign cnt_load  = wr_done && paddr == `OFS_COUNT && !running;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= pwm_pkg::ST_STOPPED;
        end else begin
            case (state_r)
                pwm_pkg::ST_STOPPED: begin
                    if (start_req) begin
                        state_r <= pwm_pkg::ST_COUNTING;
                    end
                end
                pwm_pkg::ST_COUNTING: begin
                    if (stop_req) begin
                        state_r <= pwm_pkg::ST_STOPPED;
                    end
                end
                default: state_r <= pwm_pkg::ST_STOPPED;
            endcase
        end
    end

    sawtooth_counter #(
        .CNT_W (CNT_W)
    ) sawtooth_counter_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .run      (running),
        .load     (cnt_load),
        .load_val (pwdata[CNT_W-1:0]),
        .period   (period_value_r),
        .cmp_a    (compare_a_r),
        .cmp_b    (compare_b_r),
        .count    (timer_count),
        .overflow (overflow),
        .match_a  (match_a),
        .match_b  (match_b)
    );

    // ------------------------------------------------------------
    // Output waveform
    // ------------------------------------------------------------
    always_comb begin
        force_nxt = force_act_r;
        level_nxt = level_r;
        if (start_req) begin
            level_nxt = 1'b0;
            if (forced_duty_at_start_a_r && is_forced(forced_duty_sel_a_r)) begin
                force_nxt = forced_duty_sel_a_r;
            end else begin
                force_nxt = `DUTY_NONE;
            end
        end else if (running) begin
            // Compare match has priority over the cycle-end low
            if (match_a) begin
                level_nxt = 1'b1;
            end else if (overflow) begin
                level_nxt = 1'b0;
            end
            // Forcing changed during counting waits for the cycle end
            if (overflow) begin
                force_nxt = is_forced(forced_duty_sel_a_r) ?
                            forced_duty_sel_a_r : `DUTY_NONE;
            end
        end
        // Level keeps tracking matches while forced, pin stays fixed
        out_nxt = pin_level(force_nxt, level_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_act_r <= `DUTY_NONE;
            level_r     <= 1'b0;
            pwm_out_a   <= 1'b0;
        end else begin
            force_act_r <= force_nxt;
            level_r     <= level_nxt;
            pwm_out_a   <= out_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    // Events are raised whether or not the pin is forced
    assign events[`EVT_OVERFLOW_BIT] = overflow;
    assign events[`EVT_MATCH_A_BIT]  = match_a;
    assign events[`EVT_MATCH_B_BIT]  = match_b;

    genvar gi;
    generate
        for (gi = 0; gi < `EVT_W; gi++) begin : g_status
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    status_r[gi] <= 1'b0;
                end else if (events[gi]) begin
                    status_r[gi] <= 1'b1;
                end else if (wr_done && paddr == `OFS_STATUS_CLR && pwdata[gi]) begin
                    status_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & irq_en_r);
        end
    end

endmodule
